// [flash_params.svh]
// Opcodes, field positions, reset values and timing figures of the flash
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

// Command codes
`define OP_WRITE_ENABLE 8'h06
`define OP_ERASE_SEC 8'h44
`define OP_PROG_SEC 8'h42
`define OP_READ_SEC 8'h48
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_DUAL_IO 8'hBB
`define OP_QUAD_IO 8'hEB
`define OP_QUAD_WORD 8'hE7
`define CRM_RESET_CODE 8'hFF
`define CRM_MODE_TAG 4'hA

// Array layout and reset values
`define AREA_COUNT 3
`define AREA_BYTES 512
`define ERASED_BYTE 8'hFF
`define AREA_HIGH_ZERO 8'h00
`define AREA_MID_ZERO 3'h0
`define AREA_FIRST 4'h1
`define AREA_LAST 4'h3
`define LOCKS_RESET 3'h0

// Bit positions in a frame, counted from 1
`define OPCODE_BITS 6'd8
`define ADDR_END_BITS 6'd32
`define DATA_START_BITS 6'd40
`define BYTE_LAST_BITS 6'd47
`define MODE_DONE_BITS 6'd39
`define CRM_FIRST_BIT 6'd9
`define CRM_BYTE_DONE 6'd15

// Timing: system clock rate and cycle times in microseconds
`define CLK_MHZ 20
`define SECTOR_ERASE_TIME_US 100000
`define PAGE_PROGRAM_TIME_US 700
`define SUSPEND_TIME_US 20

`endif

// [flash_pkg.sv]
// Shared types for the security area flash controller
package flash_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_SUSP_WAIT = 2'b10,
    ST_SUSPENDED = 2'b11
  } cycle_state_e;

  typedef enum logic [0:0] {
    KIND_ERASE = 1'b0,
    KIND_PROG = 1'b1
  } cycle_kind_e;

  // What the link logic saw during the last frame
  typedef struct packed {
    logic [7:0] opcode;
    logic [5:0] bits;
    logic [23:0] addr;
    logic [9:0] data_bytes;
  } frame_s;

  // Status seen by software
  typedef struct packed {
    logic write_in_progress_flag;
    logic write_enable_latch;
    logic suspended;
    logic [2:0] security_area_lock_bits;
  } status_s;

endpackage

// [flash_security_ctrl.sv]
// Security area erase, program, read, suspend and continuous read control
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_security_ctrl #(
  parameter int unsigned ERASE_CYCLES =
    `SECTOR_ERASE_TIME_US * `CLK_MHZ,
  parameter int unsigned PROGRAM_CYCLES =
    `PAGE_PROGRAM_TIME_US * `CLK_MHZ
) (
  // System clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Serial link from the host
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Lock control
  input wire logic [2:0] lock_set_i,
  // Status
  output flash_pkg::status_s status_o,
  output logic continuous_read_o
);
  localparam logic [8:0] SUS_CYCLES = 9'(`SUSPEND_TIME_US * `CLK_MHZ);
  localparam int SUSP_LIMIT = `SUSPEND_TIME_US * `CLK_MHZ + 1;

  // Link domain state
  logic in_frame_q;
  logic frame_tog_q;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [7:0] din_q;
  logic [7:0] byte_in;
  logic [9:0] nbytes_q;
  logic crm_q;
  logic [7:0] pbuf_q [`AREA_BYTES];
  logic [8:0] wr_ptr;
  logic [8:0] rd_ptr_q;
  logic [7:0] sh_q;
  logic [7:0] rd_byte;
  logic prog_open;
  logic prog_byte;
  logic fast_op;
  logic area_ok;
  logic [1:0] area_idx;

  // System domain state
  logic cs_n_s;
  logic cs_prev_q;
  logic [2:0] lock_s;
  logic frame_seen_q;
  flash_pkg::frame_s fr;
  flash_pkg::cycle_state_e st_q;
  flash_pkg::cycle_kind_e kind_q;
  logic [2:0] target_q;
  logic [31:0] timer_q;
  logic [8:0] sus_cnt_q;
  logic wel_q;
  logic [2:0] lock_q;
  logic [7:0] mem_q [`AREA_COUNT][`AREA_BYTES];
  logic cmd_ok;
  logic cmd8;
  logic do_write_enable_command;
  logic do_erase;
  logic do_prog;
  logic do_susp;
  logic do_res;
  logic cyc_end;

  // Frame marker: cleared by deselect, set by the first clock of a frame
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      in_frame_q <= 1'b0;
    end else begin
      in_frame_q <= 1'b1;
    end
  end

  // Bit position of the bit taken on this edge, data bytes repeat 40..47
  always_comb begin
    if (!in_frame_q) begin
      cnt_d = crm_q ? `CRM_FIRST_BIT : 6'd1; // Mode frames skip opcode
    end else if (cnt_q == `BYTE_LAST_BITS) begin
      cnt_d = `DATA_START_BITS;
    end else begin
      cnt_d = cnt_q + 6'd1;
    end
  end

  assign byte_in = {din_q[6:0], si_i};
  assign fast_op = (op_q == `OP_DUAL_IO) || (op_q == `OP_QUAD_IO) ||
                   (op_q == `OP_QUAD_WORD);
  assign area_ok = (addr_q[23:16] == `AREA_HIGH_ZERO) &&
                   (addr_q[11:9] == `AREA_MID_ZERO) &&
                   (addr_q[15:12] >= `AREA_FIRST) &&
                   (addr_q[15:12] <= `AREA_LAST);
  assign area_idx = 2'(addr_q[15:12] - `AREA_FIRST);

  // Opcode and address shift in on rising edges
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 6'h00;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      din_q <= 8'h00;
      frame_tog_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      din_q <= byte_in;
      if (!in_frame_q) begin
        frame_tog_q <= ~frame_tog_q;
      end
      if (!in_frame_q && crm_q) begin
        op_q <= `OP_QUAD_IO;
      end else if (cnt_d <= `OPCODE_BITS) begin
        op_q <= {op_q[6:0], si_i};
      end
      if (cnt_d > `OPCODE_BITS && cnt_d <= `ADDR_END_BITS) begin
        addr_q <= {addr_q[22:0], si_i};
      end
    end
  end

  // Program data bytes follow the address directly, no dummy byte
  assign prog_open = in_frame_q && (cnt_d == `OPCODE_BITS) &&
                     (byte_in == `OP_PROG_SEC);
  assign prog_byte = in_frame_q && (op_q == `OP_PROG_SEC) &&
                     ((cnt_q == `MODE_DONE_BITS) ||
                      (cnt_q == `BYTE_LAST_BITS));
  assign wr_ptr = addr_q[8:0] + nbytes_q[8:0];

  // Count of received data bytes, saturating at one area
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nbytes_q <= 10'h000;
    end else if (prog_open) begin
      nbytes_q <= 10'h000;
    end else if (prog_byte && nbytes_q != 10'(`AREA_BYTES)) begin
      nbytes_q <= nbytes_q + 10'h001;
    end
  end

  // Page buffer; untouched bytes stay FF so they leave the area unchanged
  for (genvar b = 0; b < `AREA_BYTES; b++) begin : g_pbuf
    always_ff @(posedge sclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        pbuf_q[b] <= `ERASED_BYTE;
      end else if (prog_open) begin
        pbuf_q[b] <= `ERASED_BYTE;
      end else if (prog_byte && wr_ptr == 9'(b)) begin
        pbuf_q[b] <= byte_in;
      end
    end
  end

  // Continuous read mode, owned by the link domain
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      crm_q <= 1'b0;
    end else if (crm_q && in_frame_q && cnt_q == `CRM_BYTE_DONE &&
                 byte_in == `CRM_RESET_CODE) begin
      crm_q <= 1'b0;
    end else if (in_frame_q && fast_op && cnt_q == `MODE_DONE_BITS) begin
      crm_q <= (byte_in[7:4] == `CRM_MODE_TAG);
    end
  end

  chk_crm_reset: assert property (@(posedge sclk_i) disable iff (!rstn_i)
    crm_q && in_frame_q && cnt_q == `CRM_BYTE_DONE &&
    byte_in == `CRM_RESET_CODE |=> !crm_q)
    else $error("continuous read not cleared by reset code");

  // The next link edge is usually the first edge of the following frame
  chk_crm_enter: assert property (@(posedge sclk_i) disable iff (!rstn_i)
    in_frame_q && fast_op && cnt_q == `MODE_DONE_BITS &&
    byte_in[7:4] == `CRM_MODE_TAG |=> crm_q)
    else $error("mode bits did not hold continuous read");

  // Area contents are quasi-static while the host reads them
  assign rd_byte = area_ok ? mem_q[area_idx][rd_ptr_q] : `ERASED_BYTE;

  // Read data shifts out on falling edges, most significant bit first
  always_ff @(negedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_ptr_q <= 9'h000;
      sh_q <= 8'h00;
      so_o <= 1'b0;
    end else if (cnt_q < `DATA_START_BITS) begin
      rd_ptr_q <= addr_q[8:0];
    end else if (cnt_q == `DATA_START_BITS) begin
      so_o <= rd_byte[7];
      sh_q <= {rd_byte[6:0], 1'b0};
      rd_ptr_q <= rd_ptr_q + 9'h001; // Wraps 1FF to 000
    end else begin
      so_o <= sh_q[7];
      sh_q <= {sh_q[6:0], 1'b0};
    end
  end

  assign so_oe_o = !cs_n_i && in_frame_q && (op_q == `OP_READ_SEC) &&
                   (cnt_q >= `DATA_START_BITS);
  assign continuous_read_o = crm_q;

  chk_read_wrap: assert property (@(negedge sclk_i) disable iff (!rstn_i)
    rd_ptr_q == 9'h1FF && cnt_q == `DATA_START_BITS
    |=> rd_ptr_q == 9'h000)
    else $error("read offset did not wrap to zero");

  // Deselect and lock pins cross into the system domain
  flash_sync2 #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_cs_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i(cs_n_i),
    .sync_o(cs_n_s)
  );

  flash_sync2 #(
    .WIDTH(3),
    .RESET_VAL(3'h0)
  ) u_lock_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i(lock_set_i),
    .sync_o(lock_s)
  );

  // Frame record is stable once deselect has passed the synchroniser;
  // the toggle rejects a select pulse that carried no clock at all
  assign fr = '{opcode: op_q, bits: cnt_q, addr: addr_q,
                data_bytes: nbytes_q};
  assign cmd_ok = cs_n_s && !cs_prev_q && (frame_tog_q != frame_seen_q);
  assign cmd8 = (fr.bits == `OPCODE_BITS);
  assign do_write_enable_command = cmd_ok && cmd8 && fr.opcode == `OP_WRITE_ENABLE;
  assign do_erase = cmd_ok && cmd8 && fr.opcode == `OP_ERASE_SEC &&
                    wel_q && st_q == flash_pkg::ST_IDLE &&
                    (lock_q != 3'h7);
  assign do_prog = cmd_ok && fr.opcode == `OP_PROG_SEC &&
                   fr.data_bytes != 10'h000 && area_ok &&
                   !lock_q[area_idx] && wel_q &&
                   st_q == flash_pkg::ST_IDLE;
  assign do_susp = cmd_ok && cmd8 && fr.opcode == `OP_SUSPEND &&
                   st_q == flash_pkg::ST_RUN;
  assign do_res = cmd_ok && cmd8 && fr.opcode == `OP_RESUME &&
                  st_q == flash_pkg::ST_SUSPENDED;
  assign cyc_end = (st_q == flash_pkg::ST_RUN) && (timer_q == 32'h0) &&
                   !do_susp;

  // Deselect edge detection and frame bookkeeping
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_prev_q <= 1'b1;
      frame_seen_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_n_s;
      if (cmd_ok) begin
        frame_seen_q <= frame_tog_q;
      end
    end
  end

  // Write enable latch, dropped as the cycle starts
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wel_q <= 1'b0;
    end else if (do_erase || do_prog) begin
      wel_q <= 1'b0;
    end else if (do_write_enable_command) begin
      wel_q <= 1'b1;
    end
  end

  // Lock bits only accumulate; nothing but power loss clears them
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_q <= `LOCKS_RESET;
    end else begin
      lock_q <= lock_q | lock_s;
    end
  end

  // Cycle sequencer with suspend and resume
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= flash_pkg::ST_IDLE;
      kind_q <= flash_pkg::KIND_ERASE;
      target_q <= 3'h0;
      timer_q <= 32'h0;
      sus_cnt_q <= 9'h000;
    end else begin
      case (st_q)
        flash_pkg::ST_IDLE: begin
          if (do_erase) begin
            st_q <= flash_pkg::ST_RUN;
            kind_q <= flash_pkg::KIND_ERASE;
            target_q <= ~lock_q;
            timer_q <= ERASE_CYCLES - 32'h1;
          end else if (do_prog) begin
            st_q <= flash_pkg::ST_RUN;
            kind_q <= flash_pkg::KIND_PROG;
            target_q <= 3'(3'h1 << area_idx);
            timer_q <= PROGRAM_CYCLES - 32'h1;
          end
        end
        flash_pkg::ST_RUN: begin
          if (do_susp) begin
            st_q <= flash_pkg::ST_SUSP_WAIT;
            sus_cnt_q <= SUS_CYCLES - 9'h001;
          end else if (timer_q == 32'h0) begin
            st_q <= flash_pkg::ST_IDLE;
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        flash_pkg::ST_SUSP_WAIT: begin
          if (sus_cnt_q == 9'h000) begin
            st_q <= flash_pkg::ST_SUSPENDED;
          end else begin
            sus_cnt_q <= sus_cnt_q - 9'h001;
          end
        end
        flash_pkg::ST_SUSPENDED: begin
          if (do_res) begin
            st_q <= flash_pkg::ST_RUN; // Timer kept its count
          end
        end
        default: begin
          st_q <= flash_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Area storage; the update lands in the final cycle of the timed cycle
  for (genvar a = 0; a < `AREA_COUNT; a++) begin : g_area
    for (genvar b = 0; b < `AREA_BYTES; b++) begin : g_byte
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          mem_q[a][b] <= `ERASED_BYTE;
        end else if (cyc_end && target_q[a]) begin
          if (kind_q == flash_pkg::KIND_ERASE) begin
            mem_q[a][b] <= `ERASED_BYTE;
          end else begin
            mem_q[a][b] <= mem_q[a][b] & pbuf_q[b];
          end
        end
      end
    end
  end

  // Status outputs, one driver for the whole word; busy covers suspend wait
  assign status_o = '{
    write_in_progress_flag: (st_q == flash_pkg::ST_RUN) ||
                            (st_q == flash_pkg::ST_SUSP_WAIT),
    write_enable_latch: wel_q,
    suspended: (st_q == flash_pkg::ST_SUSPENDED),
    security_area_lock_bits: lock_q
  };

  chk_erase_exact_len: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    st_q == flash_pkg::ST_IDLE && cmd_ok &&
    fr.opcode == `OP_ERASE_SEC && fr.bits != `OPCODE_BITS
    |=> st_q == flash_pkg::ST_IDLE)
    else $error("erase started without an exact eight bit frame");

  chk_cycle_starts: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    do_erase || do_prog
    |=> status_o.write_in_progress_flag && !wel_q)
    else $error("cycle start did not raise busy and drop latch");

  chk_cycle_ends: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    cyc_end |=> !status_o.write_in_progress_flag &&
    st_q == flash_pkg::ST_IDLE)
    else $error("busy flag stayed high after the cycle");

  chk_lock_sticky: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    ##1 (lock_q & $past(lock_q)) == $past(lock_q))
    else $error("a lock bit was cleared");

  chk_locked_refused: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    st_q == flash_pkg::ST_IDLE && cmd_ok && fr.opcode == `OP_PROG_SEC &&
    area_ok && lock_q[area_idx] |=> st_q == flash_pkg::ST_IDLE)
    else $error("program accepted on a locked area");

  chk_no_latch_start: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    st_q == flash_pkg::ST_IDLE && cmd_ok && !wel_q
    |=> st_q == flash_pkg::ST_IDLE)
    else $error("cycle started with the write enable latch clear");

  chk_prog_no_set: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    (mem_q[1][511] & ~$past(mem_q[1][511])) != 8'h00
    |-> $past(cyc_end) && kind_q == flash_pkg::KIND_ERASE)
    else $error("a bit returned to one outside an erase");

  chk_suspend_time: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    do_susp |=> status_o.write_in_progress_flag
    ##[1:SUSP_LIMIT] st_q == flash_pkg::ST_SUSPENDED &&
    !status_o.write_in_progress_flag)
    else $error("suspension not complete within the suspend time");

  chk_suspend_holds: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    st_q == flash_pkg::ST_SUSPENDED && !do_res
    |=> st_q == flash_pkg::ST_SUSPENDED)
    else $error("suspended state left without resume");

  chk_resume_busy: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    do_res |=> status_o.write_in_progress_flag &&
    timer_q == $past(timer_q))
    else $error("resume did not continue the cycle");

  chk_stray_cmds: assert property (@(posedge clock_i)
    disable iff (!rstn_i)
    st_q == flash_pkg::ST_IDLE && cmd_ok &&
    (fr.opcode == `OP_RESUME || fr.opcode == `OP_SUSPEND)
    |=> st_q == flash_pkg::ST_IDLE)
    else $error("suspend or resume acted with nothing running");

endmodule

// [flash_sync2.sv]
// Two-stage synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
module flash_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Level in and out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // First stage is read by the second stage only
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// [spi_host_model.sv]
// Host side serial controller model that drives the flash link
`timescale 1ns/1ps
module spi_host_model (
  // Link lines towards the flash
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  // Lines back from the flash
  input wire logic so_i,
  input wire logic so_oe_i
);
  logic [7:0] rx_q[$];
  logic oe_seen_q;
  logic smp_q;

  // Clock parked low and device deselected outside frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    oe_seen_q = 1'b1;
    smp_q = 1'b0;
  end

  // One bit of a 12 ns link period; output is taken at the rising edge
  task automatic bit_out(input logic d);
    #3 si_o <= d;
    #3 sclk_o <= 1'b1;
    #0.1 smp_q = so_i; // Output only moves on falling edges
    oe_seen_q &= so_oe_i;
    #5.9 sclk_o <= 1'b0;
  endtask

  // Whole bytes out, optional stray bits, then nrd bytes read back
  task automatic xfer(input logic [7:0] tx[$], input int extra,
                      input int nrd);
    logic [7:0] b;
    b = 8'h00;
    rx_q = {};
    #3.7 cs_n_o <= 1'b0; // Odd offset keeps the link unrelated to clock_i
    foreach (tx[i])
      for (int k = 7; k >= 0; k--) bit_out(tx[i][k]);
    // Stray bits only where a scenario wants a malformed frame
    repeat (extra) bit_out(1'b0);
    // Output enable is only expected over the data bits
    oe_seen_q = 1'b1;
    repeat (nrd) begin
      for (int k = 0; k < 8; k++) begin
        bit_out(~si_o); // Toggling input, since the host only listens
        b = {b[6:0], smp_q};
      end
      rx_q.push_back(b);
    end
    #3 cs_n_o <= 1'b1;
    si_o <= ~si_o; // Released line does not keep its last value
    // Deselect gap longer than four system clocks so each frame is acted on
    #300;
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the security area flash controller
`timescale 1ns/1ps
`include "flash_params.svh"
module tb_top;
  localparam int unsigned PROG_N = 30;
  localparam int unsigned ERASE_N = 50;
  logic clock_i, rstn_i, sclk, cs_n, si, so, so_oe, crm;
  logic [2:0] lock_set;
  flash_pkg::status_s st;
  int fail_count = 0;
  int n_checks = 0;
  int n;
  logic [7:0] q[$];
  logic [23:0] bad_addr[3] = '{24'h01_1000, 24'h00_4000, 24'h00_1200};

  // Device under test with shortened cycle times
  flash_security_ctrl #(.ERASE_CYCLES(ERASE_N), .PROGRAM_CYCLES(PROG_N))
  i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .si_i(si), .so_o(so), .so_oe_o(so_oe), .lock_set_i(lock_set),
    .status_o(st), .continuous_read_o(crm));

  spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
    .so_i(so), .so_oe_i(so_oe));

  // System clock, 50 ns period
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic op(input logic [7:0] c, input int extra);
    q = {c};
    host.xfer(q, extra, 0);
  endtask

  task automatic prog(input logic [23:0] a, input logic [7:0] d[$]);
    q = {`OP_PROG_SEC, a[23:16], a[15:8], a[7:0], d};
    host.xfer(q, 0, 0);
  endtask

  task automatic rd(input logic [23:0] a, input int nb);
    q = {`OP_READ_SEC, a[23:16], a[15:8], a[7:0], 8'h00};
    host.xfer(q, 0, nb);
  endtask

  // Bounded wait for the running cycle to end, counting system clocks
  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (st.write_in_progress_flag !== 1'b0 && cnt < 1000) begin
      @(negedge clock_i);
      cnt++;
    end
  endtask

  // Watchdog: whole run needs a little over 1 ms
  initial begin
    #3ms;
    fail_count++;
    summarize();
  end

  initial begin
    rstn_i = 1'b0;
    lock_set = 3'h0;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    #1ms; // Power-up delays before select and before any write
    check("status reset", 32'(st), 32'h0);
    check("crm reset", crm, 32'h0);
    rd(24'h00_11FE, 3);
    check("read wrap", {host.rx_q[0], host.rx_q[1], host.rx_q[2]},
      32'hFFFFFF);
    check("read enable", host.oe_seen_q, 32'h1);
    prog(24'h00_2000, '{8'h11});
    check("prog no latch", st.write_in_progress_flag, 32'h0);
    op(`OP_WRITE_ENABLE, 0);
    check("latch set", st.write_enable_latch, 32'h1);
    // Malformed addresses: top byte, area code, middle field
    foreach (bad_addr[i]) begin
      prog(bad_addr[i], '{8'h00});
      check("bad addr", st.write_in_progress_flag, 32'h0);
    end
    prog(24'h00_21FF, '{8'h5A, 8'h3C});
    check("prog busy", st.write_in_progress_flag, 32'h1);
    check("prog latch", st.write_enable_latch, 32'h0);
    wait_idle(n);
    check("prog time", n >= PROG_N - 8 && n <= PROG_N, 32'h1);
    rd(24'h00_21FF, 2);
    check("prog data", {host.rx_q[0], host.rx_q[1]}, 32'h5A3C);
    rd(24'h00_11FF, 1);
    check("other area", host.rx_q[0], 32'hFF);
    op(`OP_WRITE_ENABLE, 0);
    prog(24'h00_21FF, '{8'h0F});
    wait_idle(n);
    rd(24'h00_21FF, 1);
    check("and program", host.rx_q[0], 32'h0A);
    op(`OP_WRITE_ENABLE, 0);
    op(`OP_ERASE_SEC, 1);
    check("erase 9 bits", st.write_in_progress_flag, 32'h0);
    op(`OP_SUSPEND, 0);
    check("idle suspend", st.suspended, 32'h0);
    op(`OP_ERASE_SEC, 0);
    check("erase busy", st.write_in_progress_flag, 32'h1);
    op(`OP_SUSPEND, 0);
    check("suspend busy", st.write_in_progress_flag, 32'h1);
    n = 0;
    while (st.suspended !== 1'b1 && n < 1000) begin
      @(negedge clock_i);
      n++;
    end
    check("suspend time", n >= 380 && n <= 400, 32'h1);
    check("suspend idle", st.write_in_progress_flag, 32'h0);
    rd(24'h00_21FF, 1);
    check("suspend read", host.rx_q[0], 32'h0A);
    op(`OP_WRITE_ENABLE, 0);
    op(`OP_ERASE_SEC, 0);
    check("erase in susp", st.write_in_progress_flag, 32'h0);
    op(`OP_RESUME, 0);
    check("resume", {st.suspended, st.write_in_progress_flag}, 32'h1);
    wait_idle(n);
    rd(24'h00_21FF, 1);
    check("erased", host.rx_q[0], 32'hFF);
    op(`OP_RESUME, 0);
    check("stray resume", {st.suspended, st.write_in_progress_flag},
      32'h0);
    // Lock pin pulsed, then released; the lock must stay
    @(posedge clock_i) lock_set <= 3'h2;
    repeat (4) @(posedge clock_i);
    lock_set <= 3'h0;
    repeat (4) @(posedge clock_i);
    check("lock bits", st.security_area_lock_bits, 32'h2);
    op(`OP_WRITE_ENABLE, 0);
    prog(24'h00_2000, '{8'h00});
    check("locked prog", st.write_in_progress_flag, 32'h0);
    // Continuous read: only an A upper nibble holds the mode
    q = {`OP_DUAL_IO, 8'h00, 8'h10, 8'h00, 8'h5A};
    host.xfer(q, 0, 0);
    check("mode 5A", crm, 32'h0);
    q = {`OP_DUAL_IO, 8'h00, 8'h10, 8'h00, 8'hA5};
    host.xfer(q, 0, 0);
    check("mode A5", crm, 32'h1);
    op(`CRM_RESET_CODE, 0);
    check("mode reset", crm, 32'h0);
    // Power loss while suspended must leave nothing pending
    op(`OP_WRITE_ENABLE, 0);
    op(`OP_ERASE_SEC, 0);
    op(`OP_SUSPEND, 0);
    repeat (420) @(posedge clock_i);
    check("susp again", st.suspended, 32'h1);
    rstn_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    check("power loss", 32'(st), 32'h0);
    summarize();
  end
endmodule
